// ---- logic/iar_pkg.sv ----
// package for the alias remap table: register offsets, field layout, reset values
// assumes an 8-bit register port driven by the device's local control logic
package iar_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] IAR_OFS_BRIDGE_ADDR = 8'h06;
	localparam logic [7:0] IAR_OFS_BRIDGE_ALIAS = 8'h07;
	localparam logic [7:0] IAR_OFS_TARGET_ADDR_0 = 8'h08;
	localparam logic [7:0] IAR_OFS_TARGET_ADDR_1 = 8'h09;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int IAR_ADDR_MSB = 7;
	localparam int IAR_ADDR_LSB = 1;
	localparam int IAR_HOLD_BIT = 0;
	localparam logic [6:0] IAR_ADDR_OFF = 7'h00;
	localparam logic [6:0] IAR_RST_BRIDGE_ADDR = 7'h00;
	localparam logic [6:0] IAR_RST_ALIAS = 7'h00;
	localparam logic IAR_RST_HOLD = 1'b0;
	localparam logic [7:0] IAR_RDATA_NONE = 8'h00;

	// ----------------------------------------------------------------
	// forwarding destinations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IAR_DEST_BRIDGE = 2'b00,
		IAR_DEST_TARGET_0 = 2'b01,
		IAR_DEST_TARGET_1 = 2'b10,
		IAR_DEST_NONE = 2'b11
	} iar_dest_t;

	function automatic logic [6:0] iar_addr_field(input logic [7:0] byte_in);
		return byte_in[IAR_ADDR_MSB:IAR_ADDR_LSB];
	endfunction : iar_addr_field

endpackage : iar_pkg

// ---- logic/iar_alias_match.sv ----
// one alias entry: compares a request address with an alias and checks enables
// assumes all inputs come from logic on the same clock
module iar_alias_match (
	input wire logic [6:0] i_req_addr,
	input wire logic [6:0] i_alias,
	input wire logic [6:0] i_remote_addr,
	output logic o_hit
);
	import iar_pkg::*;

	// a zero alias or zero remote address closes the entry
	wire alias_open = (i_alias != IAR_ADDR_OFF);
	wire remote_open = (i_remote_addr != IAR_ADDR_OFF);

	assign o_hit = alias_open && remote_open && (i_req_addr == i_alias);

endmodule : iar_alias_match

// ---- logic/iar_remap_table.sv ----
// alias remap table for pass-through transactions toward the remote bridge
// assumes request, lock and learned-address inputs come from logic on i_ref_clk
// ----------------------------------------------------------------
// What this block does
// - holds the seven-bit remote bridge address, rewrites bridge-alias traffic to it
// - learns the remote bridge address from the control channel after receive lock
// - hold bit set blocks learning and keeps the written address
// - zero bridge address or zero bridge alias blocks all bridge access
// - accepts transactions matching the bridge alias, rewrites to bridge address
// - rewrites target alias n traffic to target address n, forwards it
// - zero target address n blocks access to remote target n
// - auto-acknowledge mode acknowledges remote writes at once, still remapped
// ----------------------------------------------------------------
module iar_remap_table #(
	parameter int NUM_TARGETS = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// register port
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// control-channel learning
	input wire logic i_rx_lock,
	input wire logic i_learned_valid,
	input wire logic [6:0] i_learned_addr,
	// target alias fields held elsewhere, auto-ack enable
	input wire logic [6:0] i_target_alias_0,
	input wire logic [6:0] i_target_alias_1,
	input wire logic i_auto_ack_en,
	// local transaction request
	input wire logic i_req_valid,
	input wire logic [6:0] i_req_addr,
	input wire logic i_req_read,
	// forwarded transaction
	output logic o_fwd_valid,
	output logic [6:0] o_fwd_addr,
	output logic o_fwd_read,
	output iar_pkg::iar_dest_t o_fwd_dest,
	output logic o_early_ack,
	output logic o_no_match
);
	import iar_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (NUM_TARGETS != 2) begin : g_bad_targets
		$error("iar_remap_table serves exactly two target entries");
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [6:0] bridge_addr_q;
	logic [6:0] bridge_addr_d;
	logic hold_q;
	logic hold_d;
	logic [6:0] bridge_alias_q;
	logic [6:0] bridge_alias_d;
	logic [6:0] target_addr_q [NUM_TARGETS];
	logic [6:0] target_addr_d [NUM_TARGETS];

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	// offset compare shared by the write strobes and the read mux
	function automatic logic reg_sel(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : reg_sel

	wire wr_bridge_addr = i_reg_wr && reg_sel(i_reg_addr, IAR_OFS_BRIDGE_ADDR);
	wire wr_bridge_alias = i_reg_wr && reg_sel(i_reg_addr, IAR_OFS_BRIDGE_ALIAS);
	wire wr_target_0 = i_reg_wr && reg_sel(i_reg_addr, IAR_OFS_TARGET_ADDR_0);
	wire wr_target_1 = i_reg_wr && reg_sel(i_reg_addr, IAR_OFS_TARGET_ADDR_1);
	wire [6:0] wr_field = iar_addr_field(i_reg_wdata);

	// ----------------------------------------------------------------
	// address learning
	// ----------------------------------------------------------------
	// learning only while locked and not held; a register write in the same cycle wins
	wire learn = i_rx_lock && i_learned_valid && !hold_q;

	always_comb begin
		bridge_addr_d = bridge_addr_q;
		hold_d = hold_q;
		if (wr_bridge_addr) begin
			bridge_addr_d = wr_field;
			hold_d = i_reg_wdata[IAR_HOLD_BIT];
		end else if (learn) begin
			bridge_addr_d = i_learned_addr;
		end
	end

	assign bridge_alias_d = wr_bridge_alias ? wr_field : bridge_alias_q;
	assign target_addr_d[0] = wr_target_0 ? wr_field : target_addr_q[0];
	assign target_addr_d[1] = wr_target_1 ? wr_field : target_addr_q[1];

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bridge_addr_q <= IAR_RST_BRIDGE_ADDR;
			hold_q <= IAR_RST_HOLD;
			bridge_alias_q <= IAR_RST_ALIAS;
		end else begin
			bridge_addr_q <= bridge_addr_d;
			hold_q <= hold_d;
			bridge_alias_q <= bridge_alias_d;
		end
	end

	// target entries reset closed: a zero address blocks the entry
	for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_target_reg
		always_ff @(posedge i_ref_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				target_addr_q[t] <= IAR_RST_ALIAS;
			end else begin
				target_addr_q[t] <= target_addr_d[t];
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	logic [7:0] rdata_d;

	// reserved bit 0 of alias and target registers reads zero
	always_comb begin
		if (reg_sel(i_reg_addr, IAR_OFS_BRIDGE_ADDR)) begin
			rdata_d = {bridge_addr_q, hold_q};
		end else if (reg_sel(i_reg_addr, IAR_OFS_BRIDGE_ALIAS)) begin
			rdata_d = {bridge_alias_q, 1'b0};
		end else if (reg_sel(i_reg_addr, IAR_OFS_TARGET_ADDR_0)) begin
			rdata_d = {target_addr_q[0], 1'b0};
		end else if (reg_sel(i_reg_addr, IAR_OFS_TARGET_ADDR_1)) begin
			rdata_d = {target_addr_q[1], 1'b0};
		end else begin
			rdata_d = IAR_RDATA_NONE;
		end
	end

	// read data lags the address by one cycle
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= IAR_RDATA_NONE;
		end else begin
			o_reg_rdata <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// alias matching
	// ----------------------------------------------------------------
	logic hit_bridge;
	logic hit_target_0;
	logic hit_target_1;

	iar_alias_match u_match_bridge (
		.i_req_addr(i_req_addr),
		.i_alias(bridge_alias_q),
		.i_remote_addr(bridge_addr_q),
		.o_hit(hit_bridge)
	);

	// target aliases come in as inputs; their registers sit outside this block
	iar_alias_match u_match_target_0 (
		.i_req_addr(i_req_addr),
		.i_alias(i_target_alias_0),
		.i_remote_addr(target_addr_q[0]),
		.o_hit(hit_target_0)
	);

	iar_alias_match u_match_target_1 (
		.i_req_addr(i_req_addr),
		.i_alias(i_target_alias_1),
		.i_remote_addr(target_addr_q[1]),
		.o_hit(hit_target_1)
	);

	// ----------------------------------------------------------------
	// remap selection
	// ----------------------------------------------------------------
	// bridge entry first, then target 0, then target 1
	wire iar_dest_t dest_sel = hit_bridge ? IAR_DEST_BRIDGE :
		hit_target_0 ? IAR_DEST_TARGET_0 :
		hit_target_1 ? IAR_DEST_TARGET_1 : IAR_DEST_NONE;
	wire [6:0] remap_addr = hit_bridge ? bridge_addr_q :
		hit_target_0 ? target_addr_q[0] :
		hit_target_1 ? target_addr_q[1] : IAR_ADDR_OFF;
	wire any_hit = (dest_sel != IAR_DEST_NONE);
	wire fwd_take = i_req_valid && any_hit;
	// with i_auto_ack_en set, matched writes acknowledged locally without waiting for the far end
	wire ack_now = fwd_take && !i_req_read && i_auto_ack_en;

	// next values of the forwarded outputs; address, read flag and destination take idle values when nothing is forwarded
	wire [6:0] fwd_addr_d = fwd_take ? remap_addr : IAR_ADDR_OFF;
	wire fwd_read_d = fwd_take && i_req_read;
	wire iar_dest_t fwd_dest_d = fwd_take ? dest_sel : IAR_DEST_NONE;
	wire no_match_d = i_req_valid && !any_hit;

	// ----------------------------------------------------------------
	// forwarded transaction outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_fwd_valid <= 1'b0;
			o_fwd_addr <= IAR_ADDR_OFF;
			o_fwd_read <= 1'b0;
			o_fwd_dest <= IAR_DEST_NONE;
			o_early_ack <= 1'b0;
			o_no_match <= 1'b0;
		end else begin
			o_fwd_valid <= fwd_take;
			o_fwd_addr <= fwd_addr_d;
			o_fwd_read <= fwd_read_d;
			o_fwd_dest <= fwd_dest_d;
			o_early_ack <= ack_now;
			o_no_match <= no_match_d;
		end
	end

endmodule : iar_remap_table

// ---- verif/iar_remote_model.sv ----
// remote side model: receive lock and learned bridge address
// assumes i_send is driven by the bench off the rising edge
module iar_remote_model (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_send,
	input wire logic [6:0] i_addr,
	output logic o_rx_lock,
	output logic o_learned_valid,
	output logic [6:0] o_learned_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_lock <= 1'b0;
			o_learned_valid <= 1'b0;
			o_learned_addr <= 7'h00;
		end else begin
			o_rx_lock <= o_rx_lock | i_send;
			o_learned_valid <= i_send;
			o_learned_addr <= i_send ? i_addr : ~o_learned_addr;
		end
	end
endmodule : iar_remote_model

// ---- verif/iar_remap_table_props.sv ----
// port checker for the alias remap table
// assumes binding onto iar_remap_table
module iar_remap_table_props (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_req_valid,
	input wire logic [6:0] i_req_addr,
	input wire logic i_req_read,
	input wire logic i_auto_ack_en,
	input wire logic o_fwd_valid,
	input wire logic [6:0] o_fwd_addr,
	input wire logic o_fwd_read,
	input wire iar_pkg::iar_dest_t o_fwd_dest,
	input wire logic o_early_ack,
	input wire logic o_no_match
);
	timeunit 1ns;
	timeprecision 1ps;
	import iar_pkg::*;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	property p_resp; i_req_valid |=> o_fwd_valid != o_no_match; endproperty
	a_resp: assert property (p_resp) else $error("no single answer");
	property p_noreq; !i_req_valid |=> !o_fwd_valid && !o_no_match; endproperty
	a_noreq: assert property (p_noreq) else $error("answer without request");
	property p_ack; o_fwd_valid |-> o_early_ack == ($past(i_auto_ack_en) && !$past(i_req_read));
	endproperty
	a_ack: assert property (p_ack) else $error("early ack wrong");
	property p_read; o_fwd_valid |-> o_fwd_read == $past(i_req_read); endproperty
	a_read: assert property (p_read) else $error("read flag wrong");
	property p_idle; !o_fwd_valid |-> o_fwd_addr == 7'h00 && o_fwd_dest == IAR_DEST_NONE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle outputs wrong");
	property p_open; o_fwd_valid |-> o_fwd_addr != 7'h00; endproperty
	a_open: assert property (p_open) else $error("closed entry used");
	property p_zero; i_req_valid && i_req_addr == 7'h00 |=> o_no_match; endproperty
	a_zero: assert property (p_zero) else $error("zero alias matched");
	property p_dest; o_fwd_valid |-> o_fwd_dest != IAR_DEST_NONE; endproperty
	a_dest: assert property (p_dest) else $error("no destination");
	property p_ack_fwd; o_early_ack |-> o_fwd_valid && !o_fwd_read; endproperty
	a_ack_fwd: assert property (p_ack_fwd) else $error("ack without forwarded write");
	property p_idle_flags; !o_fwd_valid |-> !o_fwd_read && !o_early_ack; endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("idle flags wrong");
	c_fwd: cover property (o_fwd_dest == IAR_DEST_BRIDGE);
	c_tgt1: cover property (o_fwd_dest == IAR_DEST_TARGET_1);
	c_ack: cover property (o_early_ack);
	c_miss: cover property (o_no_match);
endmodule : iar_remap_table_props
bind iar_remap_table iar_remap_table_props props_u (
	.i_ref_clk(i_ref_clk),
	.i_rstn(i_rstn),
	.i_req_valid(i_req_valid),
	.i_req_addr(i_req_addr),
	.i_req_read(i_req_read),
	.i_auto_ack_en(i_auto_ack_en),
	.o_fwd_valid(o_fwd_valid),
	.o_fwd_addr(o_fwd_addr),
	.o_fwd_read(o_fwd_read),
	.o_fwd_dest(o_fwd_dest),
	.o_early_ack(o_early_ack),
	.o_no_match(o_no_match)
);

// ---- verif/tb_iar_remap_table.sv ----
// bench for the alias remap table: registers, learning, request remap
// assumes the remote model and the bound checker
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_iar_remap_table;
	timeunit 1ns;
	timeprecision 1ps;
	import iar_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, snd = 1'b0, ae = 1'b0, rv = 1'b0, rd = 1'b0;
	logic lk, lv, fv, fr, ea, nm;
	logic [7:0] ra = 8'h00, wd = 8'h00, rdat;
	logic [6:0] la, a0 = 7'h00, a1 = 7'h00, rq = 7'h00, sa = 7'h00, fa;
	iar_dest_t fd;
	int num_errors = 0, total_checks = 0, cyc = 0;
	iar_remote_model mdl_u (.i_ref_clk(clk), .i_rstn(rstn), .i_send(snd), .i_addr(sa),
		.o_rx_lock(lk), .o_learned_valid(lv), .o_learned_addr(la));
	iar_remap_table #(.NUM_TARGETS(2)) dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_wr(wr),
		.i_reg_addr(ra), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_rx_lock(lk),
		.i_learned_valid(lv), .i_learned_addr(la), .i_target_alias_0(a0),
		.i_target_alias_1(a1), .i_auto_ack_en(ae), .i_req_valid(rv), .i_req_addr(rq),
		.i_req_read(rd), .o_fwd_valid(fv), .o_fwd_addr(fa), .o_fwd_read(fr),
		.o_fwd_dest(fd), .o_early_ack(ea), .o_no_match(nm));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		ra = a;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		ra = a;
		@(negedge clk);
		`CHK("rdata", e, rdat)
	endtask : rreg
	task automatic learn(input logic [6:0] a);
		@(negedge clk);
		snd = 1'b1;
		sa = a;
		@(negedge clk);
		snd = 1'b0;
	endtask : learn
	task automatic req(input logic [6:0] a, input logic r, input logic v, input logic [6:0] ex,
		input iar_dest_t ed, input logic ek);
		@(negedge clk);
		rv = 1'b1;
		rq = a;
		rd = r;
		@(negedge clk);
		rv = 1'b0;
		`CHK("valid", v, fv)
		`CHK("miss", !v, nm)
		`CHK("addr", ex, fa)
		`CHK("dest", ed, fd)
		`CHK("read", r & v, fr)
		`CHK("ack", ek, ea)
	endtask : req
	task automatic t_regs();
		for (int a = 5; a < 11; a++)
			rreg(8'(a), 8'h00);
		wreg(8'h0A, 8'hFF);
		rreg(8'h0A, 8'h00);
		$display("reset values done");
	endtask : t_regs
	task automatic t_learn();
		learn(7'h2A);
		rreg(8'h06, 8'h54);
		wreg(8'h06, 8'h51);
		learn(7'h33);
		rreg(8'h06, 8'h51);
		$display("learning done");
	endtask : t_learn
	task automatic t_remap();
		wreg(8'h07, 8'h20);
		ae = 1'b1;
		req(7'h10, 1'b0, 1'b1, 7'h28, IAR_DEST_BRIDGE, 1'b1);
		req(7'h10, 1'b1, 1'b1, 7'h28, IAR_DEST_BRIDGE, 1'b0);
		a0 = 7'h11;
		a1 = 7'h12;
		wreg(8'h08, 8'h60);
		req(7'h11, 1'b1, 1'b1, 7'h30, IAR_DEST_TARGET_0, 1'b0);
		req(7'h12, 1'b0, 1'b0, 7'h00, IAR_DEST_NONE, 1'b0);
		wreg(8'h09, 8'h62);
		req(7'h12, 1'b0, 1'b1, 7'h31, IAR_DEST_TARGET_1, 1'b1);
		ae = 1'b0;
		req(7'h12, 1'b0, 1'b1, 7'h31, IAR_DEST_TARGET_1, 1'b0);
		a0 = 7'h10;
		req(7'h10, 1'b0, 1'b1, 7'h28, IAR_DEST_BRIDGE, 1'b0);
		a0 = 7'h11;
		a1 = 7'h11;
		req(7'h11, 1'b1, 1'b1, 7'h30, IAR_DEST_TARGET_0, 1'b0);
		a1 = 7'h12;
		$display("remap done");
	endtask : t_remap
	task automatic t_close();
		wreg(8'h07, 8'h00);
		req(7'h10, 1'b0, 1'b0, 7'h00, IAR_DEST_NONE, 1'b0);
		req(7'h55, 1'b1, 1'b0, 7'h00, IAR_DEST_NONE, 1'b0);
		req(7'h00, 1'b0, 1'b0, 7'h00, IAR_DEST_NONE, 1'b0);
		wreg(8'h08, 8'h00);
		req(7'h11, 1'b1, 1'b0, 7'h00, IAR_DEST_NONE, 1'b0);
		$display("close done");
	endtask : t_close
	task automatic t_reset();
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		rreg(8'h06, 8'h00);
		rreg(8'h09, 8'h00);
		$display("reset done");
	endtask : t_reset
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		t_regs();
		t_learn();
		t_remap();
		t_close();
		t_reset();
		results();
	end
endmodule : tb_iar_remap_table
